// File: aud_port.sv
`timescale 1ns/1ps
// Function
// - Four lines: txd, rxd, bit clock, word align
// - Short sync: align high 1-2, low 16
// - Long sync: align 16 high, 16 low
// - One framing mode chosen by configuration
// - Host or local device role, one only
// - Align frequency equals selected rate, nine rates
// - Every sample is a 16-bit linear word
// - Long sync also carries dual mono words
// - Samples are two's complement signed
// - Words shift most significant bit first
// - Short sync bit clock 17/18 times rate
// - Long sync bit clock 32 times rate
module aud_port (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic        cfg_host,
   input  wire logic        cfg_long_sync,
   input  wire logic        cfg_sync_two,
   input  wire logic        cfg_dual_mono,
   input  wire logic [3:0]  cfg_rate,
   input  wire logic        tx_valid,
   input  wire logic [15:0] tx_left,
   input  wire logic [15:0] tx_right,
   output logic             tx_ready,
   output logic             rx_valid,
   output logic      [15:0] rx_left,
   output logic      [15:0] rx_right,
   output logic             link_locked,
   input  wire logic        bit_clk,
   output logic             bit_clk_out,
   output logic             bit_clk_oe,
   input  wire logic        audio_word_align_in,
   output logic             audio_word_align_out,
   output logic             audio_word_align_oe,
   output logic             ser_txd,
   input  wire logic        ser_rxd
);

   localparam int W = aud_pkg::WORD_W;

   // System clock side
   typedef struct packed {
      logic [aud_pkg::NCO_W-1:0] acc;
      logic                      bclk;
      logic                      oe;
      logic [W-1:0]              hold_l;
      logic [W-1:0]              hold_r;
      logic                      req;
      logic                      ready;
      logic [W-1:0]              rx_l;
      logic [W-1:0]              rx_r;
      logic                      rx_valid;
      logic                      rx_seen;
      logic                      locked;
   } aud_sys_t;

   // Bit clock side, rising edge
   typedef struct packed {
      aud_pkg::aud_link_state_t  state;
      logic [5:0]                cnt;
      logic                      wa_prev;
      logic [W-1:0]              sh_l;
      logic [W-1:0]              sh_r;
      logic [W-1:0]              tx_l;
      logic [W-1:0]              tx_r;
      logic                      ack;
      logic [W-1:0]              pub_l;
      logic [W-1:0]              pub_r;
      logic                      tgl;
   } aud_link_t;

   // Bit clock side, falling edge pin drivers
   typedef struct packed {
      logic                      txd;
      logic                      wa;
      logic                      wa_oe;
   } aud_pin_t;

   aud_sys_t                  s;
   aud_sys_t                  next_s;
   aud_link_t                 l;
   aud_link_t                 next_l;
   aud_pin_t                  p;
   aud_pin_t                  next_p;

   logic [2:0]                sys_sync;
   logic [5:0]                link_sync;
   logic                      ls_ce;
   logic                      ls_host;
   logic                      ls_long;
   logic                      ls_two;
   logic                      ls_dual;
   logic                      ls_req;
   logic [5:0]                sys_len;
   logic [aud_pkg::NCO_W-1:0] sys_step;

   // Ack, receive toggle and lock flag come over from the bit clock side
   aud_sync2 #(
      .W     (3)
   ) u_to_sys (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({l.state == aud_pkg::AUD_RUN, l.tgl, l.ack}),
      .q     (sys_sync)
   );

   // Configuration is expected to be static while a stream runs
   aud_sync2 #(
      .W     (6)
   ) u_to_link (
      .clk   (bit_clk),
      .rst_b (rst_b),
      .d     ({ce, cfg_host, cfg_long_sync, cfg_sync_two, cfg_dual_mono, s.req}),
      .q     (link_sync)
   );

   assign {ls_ce, ls_host, ls_long, ls_two, ls_dual, ls_req} = link_sync;

   assign sys_len  = aud_pkg::aud_frame_len(cfg_long_sync, cfg_sync_two);
   assign sys_step = aud_pkg::aud_nco_step(aud_pkg::aud_rate_t'(cfg_rate), sys_len);

   always_comb begin
      logic [aud_pkg::NCO_W:0] sum;
      sum             = '0;
      next_s          = s;
      next_s.rx_valid = 1'b0;
      if (ce) begin
         next_s.oe     = cfg_host;
         next_s.locked = sys_sync[2];
         // Fractional divider keeps the average rate exact for every frame length
         if (cfg_host) begin
            sum         = {1'b0, s.acc} + {1'b0, sys_step};
            next_s.acc  = sum[aud_pkg::NCO_W-1:0];
            if (sum[aud_pkg::NCO_W])
               next_s.bclk = ~s.bclk;
         end else begin
            next_s.acc  = '0;
            next_s.bclk = 1'b0;
         end
         // Words cross by a toggle handshake; the hold registers stay still until acked
         if (s.ready && tx_valid) begin
            next_s.hold_l = tx_left;
            next_s.hold_r = tx_right;
            next_s.req    = ~s.req;
            next_s.ready  = 1'b0;
         end else begin
            next_s.ready  = (sys_sync[0] == s.req);
         end
         // Published words stay put for a whole frame, far longer than the sync delay
         if (sys_sync[1] != s.rx_seen) begin
            next_s.rx_seen  = sys_sync[1];
            next_s.rx_l     = l.pub_l;
            next_s.rx_r     = l.pub_r;
            next_s.rx_valid = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s       <= '0;
         s.ready <= 1'b1;
      end else begin
         s       <= next_s;
      end
   end

   always_comb begin
      logic [5:0]         len;
      logic [5:0]         cur;
      logic               wa_rise;
      aud_pkg::aud_slot_t slot;
      len     = aud_pkg::aud_frame_len(ls_long, ls_two);
      wa_rise = 1'b0;
      cur     = l.cnt;
      slot    = '0;
      next_l  = l;
      if (ls_ce) begin
         // A local device realigns its frame on every rising align edge
         wa_rise        = ~ls_host & audio_word_align_in & ~l.wa_prev;
         next_l.wa_prev = audio_word_align_in;
         if (wa_rise)
            cur = '0;
         case (l.state)
            aud_pkg::AUD_HUNT: begin
               if (ls_host || wa_rise)
                  next_l.state = aud_pkg::AUD_RUN;
            end
            aud_pkg::AUD_RUN: begin
               next_l.state = aud_pkg::AUD_RUN;
            end
            default: begin
               next_l.state = aud_pkg::AUD_HUNT;
            end
         endcase
         slot = aud_pkg::aud_slot(cur, ls_long, ls_two);
         // Sampled on the rising edge, shifted in most significant bit first
         if (slot.valid) begin
            if (slot.half)
               next_l.sh_r = {l.sh_r[W-2:0], ser_rxd};
            else
               next_l.sh_l = {l.sh_l[W-2:0], ser_rxd};
         end
         if (cur >= len - 6'h01) begin
            next_l.cnt = '0;
            if (l.state == aud_pkg::AUD_RUN) begin
               next_l.pub_l = next_l.sh_l;
               next_l.pub_r = ls_long ? next_l.sh_r : '0;
               next_l.tgl   = ~l.tgl;
            end
            // No new word by the frame end means silence, zero in two's complement
            if (ls_req != l.ack) begin
               next_l.ack  = ls_req;
               next_l.tx_l = s.hold_l;
               next_l.tx_r = ls_dual ? s.hold_r : s.hold_l;
            end else begin
               next_l.tx_l = '0;
               next_l.tx_r = '0;
            end
         end else begin
            next_l.cnt = cur + 6'h01;
         end
      end
   end

   always_ff @(posedge bit_clk or negedge rst_b) begin
      if (!rst_b)
         l <= '0;
      else
         l <= next_l;
   end

   always_comb begin
      aud_pkg::aud_slot_t ps;
      logic [5:0]         sl;
      ps     = aud_pkg::aud_slot(l.cnt, ls_long, ls_two);
      sl     = ls_two ? aud_pkg::SYNC_TWO : aud_pkg::SYNC_ONE;
      next_p = p;
      if (ls_ce) begin
         next_p.wa_oe = ls_host;
         if (ls_long)
            next_p.wa = ls_host & (l.cnt < aud_pkg::LONG_HALF);
         else
            next_p.wa = ls_host & (l.cnt < sl);
         if (!ps.valid)
            next_p.txd = 1'b0;
         else if (ps.half)
            next_p.txd = l.tx_r[aud_pkg::LAST_BIT - ps.idx];
         else
            next_p.txd = l.tx_l[aud_pkg::LAST_BIT - ps.idx];
      end
   end

   // Pins change on the falling edge so the partner samples mid-bit
   always_ff @(negedge bit_clk or negedge rst_b) begin
      if (!rst_b)
         p <= '0;
      else
         p <= next_p;
   end

   // Four-line link plus the role-dependent drivers
   assign ser_txd              = p.txd;
   assign audio_word_align_out = p.wa;
   assign audio_word_align_oe  = p.wa_oe;
   assign bit_clk_out          = s.bclk;
   assign bit_clk_oe           = s.oe;
   assign tx_ready             = s.ready;
   assign rx_valid             = s.rx_valid;
   assign rx_left              = s.rx_l;
   assign rx_right             = s.rx_r;
   assign link_locked          = s.locked;

endmodule : aud_port

// File: aud_pkg.sv
package aud_pkg;

   localparam int unsigned CLK_HZ     = 32'h02FA_F080;
   localparam int          WORD_W     = 32'h0000_0010;
   localparam int          NCO_W      = 32'h0000_0020;
   localparam logic [5:0]  LONG_FRAME = 6'h20;
   localparam logic [5:0]  LONG_HALF  = 6'h10;
   localparam logic [5:0]  SHORT_DATA = 6'h10;
   localparam logic [5:0]  SYNC_ONE   = 6'h01;
   localparam logic [5:0]  SYNC_TWO   = 6'h02;
   localparam logic [3:0]  LAST_BIT   = 4'hF;

   // Sample rate selection, in the order of the configuration command
   typedef enum logic [3:0] {
      AUD_RATE_8K,
      AUD_RATE_11K025,
      AUD_RATE_12K,
      AUD_RATE_16K,
      AUD_RATE_22K05,
      AUD_RATE_24K,
      AUD_RATE_32K,
      AUD_RATE_44K1,
      AUD_RATE_48K
   } aud_rate_t;

   typedef enum logic {
      AUD_HUNT,
      AUD_RUN
   } aud_link_state_t;

   typedef struct packed {
      logic       valid;
      logic       half;
      logic [3:0] idx;
   } aud_slot_t;

   function automatic logic [31:0] aud_rate_hz(input aud_rate_t r);
      case (r)
         AUD_RATE_11K025: aud_rate_hz = 32'h0000_2B11;
         AUD_RATE_12K:    aud_rate_hz = 32'h0000_2EE0;
         AUD_RATE_16K:    aud_rate_hz = 32'h0000_3E80;
         AUD_RATE_22K05:  aud_rate_hz = 32'h0000_5622;
         AUD_RATE_24K:    aud_rate_hz = 32'h0000_5DC0;
         AUD_RATE_32K:    aud_rate_hz = 32'h0000_7D00;
         AUD_RATE_44K1:   aud_rate_hz = 32'h0000_AC44;
         AUD_RATE_48K:    aud_rate_hz = 32'h0000_BB80;
         default:         aud_rate_hz = 32'h0000_1F40;
      endcase
   endfunction : aud_rate_hz

   function automatic logic [5:0] aud_frame_len(input logic long_sync, input logic sync_two);
      if (long_sync)
         aud_frame_len = LONG_FRAME;
      else
         aud_frame_len = SHORT_DATA + (sync_two ? SYNC_TWO : SYNC_ONE);
   endfunction : aud_frame_len

   // Phase step that toggles the bit clock twice per bit at the chosen rate
   function automatic logic [NCO_W-1:0] aud_nco_step(input aud_rate_t r,
                                                     input logic [5:0] len);
      logic [63:0] t;
      t = ((64'(aud_rate_hz(r)) * 64'(len)) << 33) / 64'(CLK_HZ);
      aud_nco_step = t[NCO_W-1:0];
   endfunction : aud_nco_step

   // Which word and bit a frame position carries
   function automatic aud_slot_t aud_slot(input logic [5:0] cnt, input logic long_sync,
                                          input logic sync_two);
      logic [5:0] sl;
      logic [5:0] rel;
      sl       = sync_two ? SYNC_TWO : SYNC_ONE;
      rel      = cnt - sl;
      aud_slot = '0;
      if (long_sync) begin
         aud_slot.valid = 1'b1;
         aud_slot.half  = (cnt >= LONG_HALF);
         aud_slot.idx   = cnt[3:0];
      end else if (cnt >= sl && rel < SHORT_DATA) begin
         aud_slot.valid = 1'b1;
         aud_slot.idx   = rel[3:0];
      end
   endfunction : aud_slot

endpackage : aud_pkg

// File: aud_sync2.sv
`timescale 1ns/1ps
module aud_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } aud_sync_t;

   aud_sync_t s;
   aud_sync_t next_s;

   // First stage is read only by the second one
   always_comb begin
      next_s.meta = d;
      next_s.q    = s.meta;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         s <= '0;
      else
         s <= next_s;
   end

   assign q = s.q;

endmodule : aud_sync2

// File: aud_port_sva.sv
`timescale 1ns/1ps
module aud_port_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic cfg_host,
   input wire logic cfg_long_sync,
   input wire logic cfg_sync_two,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic rx_valid,
   input wire logic link_locked,
   input wire logic bit_clk,
   input wire logic bit_clk_oe,
   input wire logic audio_word_align_out,
   input wire logic audio_word_align_oe,
   input wire logic ser_txd
);
   logic [5:0] run;
   logic       prv;
   logic       vld;
   logic [5:0] hi_len;

   assign hi_len = cfg_long_sync ? 6'h10 : (cfg_sync_two ? 6'h02 : 6'h01);

   // Align run length in bit clocks; saturates so a stuck line cannot wrap back to a legal count
   always_ff @(posedge bit_clk or negedge rst_b) begin
      if (!rst_b) begin
         run <= 6'h00;
         prv <= 1'h0;
         vld <= 1'h0;
      end else begin
         prv <= audio_word_align_out;
         vld <= vld | (audio_word_align_out != prv);
         run <= (audio_word_align_out != prv) ? 6'h01 : run + {5'h00, run != 6'h3F};
      end
   end

   property p_take_drop;
      @(posedge clk) disable iff (!rst_b) ce && tx_valid && tx_ready |=> !tx_ready;
   endproperty
   a_take_drop: assert property (p_take_drop) else $error("ready kept after take");
   property p_ready_hold;
      @(posedge clk) disable iff (!rst_b) tx_ready && !(ce && tx_valid) |=> tx_ready;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready lost with no take");
   property p_rxv_pulse;
      @(posedge clk) disable iff (!rst_b) rx_valid |=> !rx_valid;
   endproperty
   a_rxv_pulse: assert property (p_rxv_pulse) else $error("rx_valid too long");
   property p_local_off;
      @(posedge clk) disable iff (!rst_b) !cfg_host |-> !bit_clk_oe && !audio_word_align_oe;
   endproperty
   a_local_off: assert property (p_local_off) else $error("local role drives pins");
   property p_rx_locked;
      @(posedge clk) disable iff (!rst_b) rx_valid |-> link_locked;
   endproperty
   a_rx_locked: assert property (p_rx_locked) else $error("word before lock");
   property p_edge_phase;
      @(posedge clk) disable iff (!rst_b)
         $changed(ser_txd) || $changed(audio_word_align_out) |-> !bit_clk;
   endproperty
   a_edge_phase: assert property (p_edge_phase) else $error("pin moved on rising");
   property p_sync_high;
      @(posedge bit_clk) disable iff (!rst_b)
         vld && audio_word_align_oe && prv && !audio_word_align_out |-> run == hi_len;
   endproperty
   a_sync_high: assert property (p_sync_high) else $error("align high length");
   property p_sync_low;
      @(posedge bit_clk) disable iff (!rst_b)
         vld && audio_word_align_oe && !prv && audio_word_align_out |-> run == 6'h10;
   endproperty
   a_sync_low: assert property (p_sync_low) else $error("align low length");

   c_take: cover property (@(posedge clk) ce && tx_valid && tx_ready);
   c_rx: cover property (@(posedge clk) rx_valid);
   c_sync: cover property (@(posedge bit_clk) vld && prv && !audio_word_align_out);
endmodule : aud_port_chk

bind aud_port aud_port_chk chk (.clk(clk), .rst_b(rst_b), .ce(ce), .cfg_host(cfg_host),
   .cfg_long_sync(cfg_long_sync), .cfg_sync_two(cfg_sync_two), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .rx_valid(rx_valid), .link_locked(link_locked), .bit_clk(bit_clk),
   .bit_clk_oe(bit_clk_oe), .audio_word_align_out(audio_word_align_out),
   .audio_word_align_oe(audio_word_align_oe), .ser_txd(ser_txd));

// File: aud_codec.sv
`timescale 1ns/1ps
module aud_codec (
   input  wire logic        master,
   input  wire logic        long_sync,
   input  wire logic        sync_two,
   input  wire logic [15:0] word_l,
   input  wire logic [15:0] word_r,
   input  wire logic        bclk,
   input  wire logic        align,
   input  wire logic        txd,
   output logic             bclk_drv,
   output logic             align_drv,
   output logic             rxd,
   output logic      [15:0] got_l,
   output logic      [15:0] got_r
);
   int          pos = -1;
   int          np;
   int          s;
   int          len;
   logic [31:0] sh;
   logic        prev;

   assign s   = sync_two ? 2 : 1;
   assign len = long_sync ? 32 : 16 + s;

   initial begin
      {bclk_drv, align_drv, rxd, prev, sh, got_l, got_r} = '0;
      #3;
      forever #40 bclk_drv = master & ~bclk_drv;
   end

   always @(posedge bclk) begin
      pos  = (align && !prev) ? 0 : (pos + 1) % len;
      prev = align;
      if (long_sync || (pos >= s && pos < s + 16))
         sh = {sh[30:0], txd};
      if (pos == len - 1) begin
         got_l = long_sync ? sh[31:16] : sh[15:0];
         got_r = sh[15:0];
      end
   end

   // Idle data slots toggle so a stale bit is never mistaken for data
   always @(negedge bclk) begin
      np        = (pos + 1) % len;
      align_drv = long_sync ? np < 16 : np < s;
      if (long_sync)
         rxd = np < 16 ? word_l[15 - np] : word_r[31 - np];
      else if (np >= s && np < s + 16)
         rxd = word_l[15 + s - np];
      else
         rxd = ~rxd;
   end
endmodule : aud_codec

// File: aud_port_tb.sv
`timescale 1ns/1ps
module aud_port_tb;
   logic        clk = 1'h0;
   logic        rst_b = 1'h0;
   logic        ce = 1'h1;
   logic        cfg_host = 1'h0;
   logic        cfg_long_sync = 1'h0;
   logic        cfg_sync_two = 1'h0;
   logic        cfg_dual_mono = 1'h0;
   logic [3:0]  cfg_rate = 4'h0;
   logic        tx_valid = 1'h0;
   logic [15:0] tx_left = 16'h0000;
   logic [15:0] tx_right = 16'h0000;
   logic [15:0] pw_l = 16'h8001;
   logic [15:0] pw_r = 16'h7FFE;
   logic        tx_ready, rx_valid, link_locked, bit_clk_out, bit_clk_oe, ser_txd;
   logic        audio_word_align_out, audio_word_align_oe, pclk, pwa, prxd, pbclk, pwa_d;
   logic [15:0] rx_left, rx_right, got_l, got_r;
   int          fails = 0;
   int          checks = 0;

   assign pclk = bit_clk_oe ? bit_clk_out : pbclk;
   assign pwa  = audio_word_align_oe ? audio_word_align_out : pwa_d;

   aud_port dut (.clk(clk), .rst_b(rst_b), .ce(ce), .cfg_host(cfg_host),
      .cfg_long_sync(cfg_long_sync), .cfg_sync_two(cfg_sync_two), .cfg_dual_mono(cfg_dual_mono),
      .cfg_rate(cfg_rate), .tx_valid(tx_valid), .tx_left(tx_left), .tx_right(tx_right),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_left(rx_left), .rx_right(rx_right),
      .link_locked(link_locked), .bit_clk(pclk), .bit_clk_out(bit_clk_out),
      .bit_clk_oe(bit_clk_oe), .audio_word_align_in(pwa),
      .audio_word_align_out(audio_word_align_out), .audio_word_align_oe(audio_word_align_oe),
      .ser_txd(ser_txd), .ser_rxd(prxd));
   aud_codec codec (.master(!cfg_host), .long_sync(cfg_long_sync), .sync_two(cfg_sync_two),
      .word_l(pw_l), .word_r(pw_r), .bclk(pclk), .align(pwa), .txd(ser_txd),
      .bclk_drv(pbclk), .align_drv(pwa_d), .rxd(prxd), .got_l(got_l), .got_r(got_r));

   always #10 clk = ~clk;

   task automatic report_and_stop;
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic hang;
      fails++;
      report_and_stop();
   endtask : hang

   task automatic step;
      @(posedge clk);
      #1;
   endtask : step

   // Config is only changed under reset; mid-stream changes garble frames
   task automatic setup(input logic h, input logic l, input logic t, input logic d,
                        input logic [3:0] r);
      step();
      rst_b = 1'h0;
      {cfg_host, cfg_long_sync, cfg_sync_two, cfg_dual_mono, cfg_rate} = {h, l, t, d, r};
      repeat (16) step();
      rst_b = 1'h1;
   endtask : setup

   task automatic send(input logic [15:0] l, input logic [15:0] r);
      for (int n = 0; tx_ready !== 1'h1; n++) begin
         if (n == 50000) hang();
         step();
      end
      {tx_left, tx_right, tx_valid} = {l, r, 1'h1};
      step();
      tx_valid = 1'h0;
   endtask : send

   // Silence frames come first; the first non-zero word seen must be the one sent
   task automatic codec_got(input logic [15:0] el, input logic [15:0] er);
      int n = 0;
      while (n < 60000 && got_l !== 16'h0000) begin
         n++;
         step();
      end
      while (n < 60000 && got_l === 16'h0000) begin
         n++;
         step();
      end
      if (n == 60000) hang();
      chk("codec_l", got_l, el);
      chk("codec_r", got_r, er);
   endtask : codec_got

   // Skips the first words, which may come from a frame caught mid-way
   task automatic expect_rx(input logic [15:0] el, input logic [15:0] er);
      int k = 3;
      for (int n = 0; k > 0; n++) begin
         if (n == 80000) hang();
         step();
         k -= int'(rx_valid === 1'h1);
      end
      chk("rx_left", rx_left, el);
      chk("rx_right", rx_right, er);
   endtask : expect_rx

   task automatic s_host_long;
      setup(1'h1, 1'h1, 1'h0, 1'h1, aud_pkg::AUD_RATE_48K);
      send(16'hA5C3, 16'h0F1E);
      codec_got(16'hA5C3, 16'h0F1E);
      expect_rx(pw_l, pw_r);
   endtask : s_host_long

   task automatic s_short(input logic two);
      setup(1'h1, 1'h0, two, 1'h0, aud_pkg::AUD_RATE_48K);
      send(16'h8000, 16'h1234);
      codec_got(16'h8000, 16'h8000);
      expect_rx(pw_l, 16'h0000);
   endtask : s_short

   task automatic s_local;
      setup(1'h0, 1'h1, 1'h0, 1'h0, aud_pkg::AUD_RATE_8K);
      chk("clk_oe", bit_clk_oe, 1'h0);
      chk("wa_oe", audio_word_align_oe, 1'h0);
      send(16'h7FFF, 16'h1111);
      codec_got(16'h7FFF, 16'h7FFF);
      expect_rx(pw_l, pw_r);
      chk("locked", link_locked, 1'h1);
   endtask : s_local

   // Enable low must freeze the host clock and refuse an offered word
   task automatic s_hold;
      int   c = 0;
      logic b;
      setup(1'h1, 1'h1, 1'h0, 1'h0, aud_pkg::AUD_RATE_48K);
      ce = 1'h0;
      {tx_left, tx_valid} = {16'h1357, 1'h1};
      b = bit_clk_out;
      repeat (40) begin
         step();
         c += int'(bit_clk_out !== b);
      end
      chk("hold_clk", c, 0);
      chk("hold_ready", tx_ready, 1'h1);
      {tx_valid, ce} = {1'h0, 1'h1};
   endtask : s_hold

   // Last pass repeats the top rate in short sync so the 17-clock frame is timed too
   task automatic s_rates;
      int   hz[10] = '{8000, 11025, 12000, 16000, 22050, 24000, 32000, 44100, 48000, 48000};
      int   n;
      int   k;
      int   e;
      logic p;
      for (int r = 0; r < 10; r++) begin
         setup(1'h1, r < 9, 1'h0, 1'h0, 4'(r > 8 ? 8 : r));
         {n, k, p, e} = {32'h0, 32'h0, 1'h1, 50000000 / hz[r]};
         for (int c = 0; c < 30000 && k < 2; c++) begin
            step();
            n++;
            if (audio_word_align_out && !p) begin
               k++;
               if (k == 1) n = 0;
            end
            p = audio_word_align_out;
         end
         if (k < 2) hang();
         chk("align_period", 32'(n > e - 3 && n < e + 3), 1'h1);
      end
   endtask : s_rates

   initial begin
      s_host_long();
      s_short(1'h0);
      s_short(1'h1);
      s_local();
      s_hold();
      s_rates();
      report_and_stop();
   end
endmodule : aud_port_tb
